// ---- src/ctp_pkg.sv ----
// shared constants for the transmit port control block
package ctp_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses = index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PORT_CTL   = 8'h33;
    localparam logic [7:0] IDX_CAL_CTL    = 8'h34;
    localparam logic [7:0] IDX_PASS_STS   = 8'h35;
    localparam logic [7:0] IDX_FWD_CTL    = 8'h38;
    localparam logic [9:0] ADDR_PORT_CTL  = {IDX_PORT_CTL, 2'b00};
    localparam logic [9:0] ADDR_CAL_CTL   = {IDX_CAL_CTL, 2'b00};
    localparam logic [9:0] ADDR_PASS_STS  = {IDX_PASS_STS, 2'b00};
    localparam logic [9:0] ADDR_FWD_CTL   = {IDX_FWD_CTL, 2'b00};
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_ENABLE      = 0;
    localparam int BIT_FREE_CLK    = 1;
    localparam int LSB_FORCE_LP    = 2;
    localparam int LSB_LANES       = 4;
    localparam int BIT_INIT_CAL    = 6;
    localparam int BIT_PERIODIC    = 0;
    localparam int BIT_SINGLE      = 1;
    localparam int BIT_INVERT      = 2;
    localparam int BIT_PASS_MODE   = 3;
    localparam logic [7:0] RST_PORT_CTL = 8'h00;
    localparam logic [7:0] RST_CAL_CTL  = 8'h40;
    localparam logic [7:0] MASK_PORT_CTL = 8'h7F;
    localparam logic [7:0] MASK_CAL_CTL  = 8'h0F;
    localparam logic [1:0] LP_NORMAL    = 2'b00;
    localparam logic [1:0] LP_DATA      = 2'b01;
    localparam logic [1:0] LP_ALL       = 2'b11;
    // ------------------------------------------------------------
    // timing and sizes
    // ------------------------------------------------------------
    localparam int CLK_NS          = 10;
    localparam int CAL_BYTES_NS    = 1000;
    localparam int CAL_BYTES       = CAL_BYTES_NS / (CLK_NS * 8);
    localparam logic [7:0] CAL_LEN = 8'(CAL_BYTES);
    localparam logic [7:0] PAT_BASE = 8'h55;
    localparam int FIFO_DEPTH      = 16;
    localparam int DATA_W          = 8;
    localparam int NUM_RX          = 2;
    localparam int NUM_LANES       = 4;
endpackage

// ---- src/ctp_sync.sv ----
// two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module ctp_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic meta;
        logic sync;
    } ctp_sync_t;
    ctp_sync_t s_q;
    ctp_sync_t s_d;
    always_comb begin
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign dout = s_q.sync;
endmodule
`default_nettype wire

// ---- src/ctp_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ctp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } ctp_fifo_t;
    ctp_fifo_t f_q;
    ctp_fifo_t f_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;
    assign inReady  = (f_q.cnt != (AW+1)'(DEPTH));
    assign outValid = (f_q.cnt != '0);
    assign outData  = mem[f_q.rd];
    assign push = inValid && inReady;
    assign pop  = outValid && outReady;
    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.wr = f_q.wr + 1'b1;
        end
        if (pop) begin
            f_d.rd = f_q.rd + 1'b1;
        end
        f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[f_q.wr] <= inData;
        end
    end
endmodule
`default_nettype wire

// ---- src/ctp_port_ctrl.sv ----
// transmit port control: registers, calibration sequencing, lane gating
// ------------------------------------------------------------
// Summary of operation
// - output drives lanes only while enable bit is one
// - free running clock keeps clock lane toggling after first packet
// - force field: 00 normal, 01 data lanes LP00, 11 all LP00
// - lane count field: 00 four, 01 three, 10 two, 11 one lane
// - initial calibration sent at start before any high speed data
// - pass mode 0 any enabled port valid, 1 all enabled valid
// - calibration pattern 01010101 first bit 0, invert gives 10101010
// - writing one-shot request sends one sequence at next idle
// - one-shot request bit clears itself after its sequence is sent
// - periodic sequence is the alternating bit pattern
// - periodic enable sends a sequence after each frame end
// - pass shows active valid delivery, cleared on transmit error
// ------------------------------------------------------------
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ctp_port_ctrl (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [31:0]                wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_we_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic                            wb_ack_o,
    input  wire logic [ctp_pkg::DATA_W-1:0] pixData,
    input  wire logic                       pixValid,
    output logic                            pixReady,
    input  wire logic                       frameEnd,
    input  wire logic [ctp_pkg::NUM_RX-1:0] rxEnabled,
    input  wire logic [ctp_pkg::NUM_RX-1:0] rxVideoValid,
    input  wire logic                       txError,
    input  wire logic                       byteClk,
    output logic [ctp_pkg::NUM_LANES-1:0]   laneData,
    output logic [ctp_pkg::NUM_LANES-1:0]   laneHs,
    output logic                            clkLaneRun,
    output logic                            clkLaneHs,
    output logic                            txActive,
    output logic                            calBusy,
    output logic                            txPass
);
    typedef enum {ST_INIT, ST_IDLE, ST_DATA, ST_CAL} ctp_state_t;
    typedef struct packed {
        logic [7:0]                   portCtl;
        logic [7:0]                   calCtl;
        logic                         dupMode;
        ctp_state_t                   st;
        logic [7:0]                   calCnt;
        logic                         periodicPend;
        logic                         firstPkt;
        logic                         bclkPrev;
        logic                         pass;
        logic [31:0]                  rdat;
        logic                         ack;
        logic [ctp_pkg::DATA_W-1:0]   dataByte;
        logic [ctp_pkg::NUM_LANES-1:0] laneD;
        logic [ctp_pkg::NUM_LANES-1:0] laneH;
        logic                         clkRun;
        logic                         clkHs;
        logic                         active;
        logic                         busy;
    } ctp_regs_t;
    ctp_regs_t r_q;
    ctp_regs_t r_d;

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    logic bclk;
    logic frameEndS;
    logic errS;
    ctp_sync uBclkSync (.clk(clk), .rst_b(rst_b), .din(byteClk), .dout(bclk));
    ctp_sync uFeSync (.clk(clk), .rst_b(rst_b), .din(frameEnd), .dout(frameEndS));
    ctp_sync uErrSync (.clk(clk), .rst_b(rst_b), .din(txError), .dout(errS));
    logic [ctp_pkg::NUM_RX-1:0] vidS;
    genvar gi;
    generate
        for (gi = 0; gi < ctp_pkg::NUM_RX; gi++) begin : gVid
            ctp_sync uVs (.clk(clk), .rst_b(rst_b), .din(rxVideoValid[gi]), .dout(vidS[gi]));
        end
    endgenerate

    // ------------------------------------------------------------
    // data buffer
    // ------------------------------------------------------------
    logic [ctp_pkg::DATA_W-1:0] fOut;
    logic fValid;
    logic fPop;
    ctp_fifo #(.WIDTH(ctp_pkg::DATA_W), .DEPTH(ctp_pkg::FIFO_DEPTH)) uFifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .inData   (pixData),
        .inValid  (pixValid),
        .inReady  (pixReady),
        .outData  (fOut),
        .outValid (fValid),
        .outReady (fPop)
    );

    logic enable;
    logic [1:0] forceLp;
    logic [1:0] laneSel;
    logic byteTick;
    logic [ctp_pkg::NUM_LANES-1:0] laneMask;
    logic [7:0] pattern;
    logic anyOk;
    logic allOk;
    logic wbReq;
    logic [9:0] byteAdr;
    logic [7:0] beatIdx;
    assign enable   = r_q.portCtl[ctp_pkg::BIT_ENABLE];
    assign forceLp  = r_q.portCtl[ctp_pkg::LSB_FORCE_LP +: 2];
    assign laneSel  = r_q.portCtl[ctp_pkg::LSB_LANES +: 2];
    // edge of sampled byte clock paces the lanes
    assign byteTick = bclk && !r_q.bclkPrev;
    assign wbReq    = wb_cyc_i && wb_stb_i && !r_q.ack;
    assign byteAdr  = wb_adr_i[9:0];
    // pop on the idle-to-data beat too, so no stale byte goes out first
    assign fPop     = byteTick && enable && fValid && (r_q.st == ST_DATA || (r_q.st == ST_IDLE
                      && !r_q.calCtl[ctp_pkg::BIT_SINGLE] && !r_q.periodicPend));

    always_comb begin
        // lane count to active lane mask
        case (laneSel)
            2'b00:   laneMask = 4'hF;
            2'b01:   laneMask = 4'h7;
            2'b10:   laneMask = 4'h3;
            default: laneMask = 4'h1;
        endcase
        // top bit goes first, a 0 unless inverted
        pattern = r_q.calCtl[ctp_pkg::BIT_INVERT] ? ~ctp_pkg::PAT_BASE : ctp_pkg::PAT_BASE;
        beatIdx = ctp_pkg::CAL_LEN - r_q.calCnt;
        anyOk = |(rxEnabled & vidS);
        allOk = (rxEnabled != '0) && ((rxEnabled & vidS) == rxEnabled);
    end

    always_comb begin
        r_d = r_q;
        r_d.bclkPrev = bclk;
        r_d.ack = 1'b0;
        // ------------------------------------------------------------
        // wishbone slave, one wait state, unmapped reads return zero
        // ------------------------------------------------------------
        if (wbReq) begin
            r_d.ack = 1'b1;
            r_d.rdat = '0;
            case (byteAdr)
                ctp_pkg::ADDR_PORT_CTL: r_d.rdat[7:0] = r_q.portCtl;
                ctp_pkg::ADDR_CAL_CTL:  r_d.rdat[7:0] = r_q.calCtl;
                ctp_pkg::ADDR_PASS_STS: r_d.rdat[0]   = r_q.pass;
                ctp_pkg::ADDR_FWD_CTL:  r_d.rdat[0]   = r_q.dupMode;
                default:                r_d.rdat      = '0;
            endcase
            if (wb_we_i && wb_sel_i[0]) begin
                case (byteAdr)
                    ctp_pkg::ADDR_PORT_CTL:
                        r_d.portCtl = wb_dat_i[7:0] & ctp_pkg::MASK_PORT_CTL;
                    ctp_pkg::ADDR_CAL_CTL: begin
                        // a pending request stays set; writes only add to it
                        r_d.calCtl = (wb_dat_i[7:0] & ctp_pkg::MASK_CAL_CTL)
                                   | (r_q.calCtl & 8'h02) | 8'h40;
                    end
                    ctp_pkg::ADDR_FWD_CTL: r_d.dupMode = wb_dat_i[0];
                    default: ;
                endcase
            end
        end
        // remember frame end for the next idle gap
        if (frameEndS && r_q.calCtl[ctp_pkg::BIT_PERIODIC]) begin
            r_d.periodicPend = 1'b1;
        end
        // ------------------------------------------------------------
        // sequencer
        // ------------------------------------------------------------
        case (r_q.st)
            ST_INIT: begin
                // initial calibration precedes any high speed data
                if (enable && byteTick) begin
                    r_d.calCnt = ctp_pkg::CAL_LEN;
                    r_d.st = r_q.portCtl[ctp_pkg::BIT_INIT_CAL] ? ST_CAL : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!enable) begin
                    r_d.st = ST_INIT;
                end else if (byteTick) begin
                    if (r_q.calCtl[ctp_pkg::BIT_SINGLE] || r_q.periodicPend) begin
                        r_d.st = ST_CAL;
                        r_d.calCnt = ctp_pkg::CAL_LEN;
                    end else if (fValid) begin
                        r_d.st = ST_DATA;
                        r_d.dataByte = fOut;
                        r_d.firstPkt = 1'b1;
                    end
                end
            end
            ST_DATA: begin
                if (!enable) begin
                    r_d.st = ST_INIT;
                end else if (fPop) begin
                    r_d.dataByte = fOut;
                    r_d.firstPkt = 1'b1;
                end else if (byteTick) begin
                    r_d.st = ST_IDLE;
                end
            end
            ST_CAL: begin
                if (!enable) begin
                    r_d.st = ST_INIT;
                end else if (byteTick) begin
                    r_d.calCnt = r_q.calCnt - 8'h01;
                    if (r_q.calCnt == 8'h01) begin
                        r_d.st = ST_IDLE;
                        r_d.periodicPend = 1'b0;
                        // self clear once the sequence is out
                        r_d.calCtl[ctp_pkg::BIT_SINGLE] = 1'b0;
                    end
                end
            end
            default: r_d.st = ST_INIT;
        endcase
        // a frame end in the closing cycle is not lost
        if (frameEndS && r_q.calCtl[ctp_pkg::BIT_PERIODIC]) begin
            r_d.periodicPend = 1'b1;
        end
        // a new single request in the closing cycle wins over the clear
        if (wbReq && wb_we_i && wb_sel_i[0] && byteAdr == ctp_pkg::ADDR_CAL_CTL
            && wb_dat_i[ctp_pkg::BIT_SINGLE]) begin
            r_d.calCtl[ctp_pkg::BIT_SINGLE] = 1'b1;
        end
        // any or all enabled ports; error clears pass
        r_d.pass = enable && !errS && (r_q.st == ST_DATA || r_q.pass)
                 && (r_q.calCtl[ctp_pkg::BIT_PASS_MODE] ? allOk : anyOk);
        r_d.active = r_d.st == ST_DATA;
        r_d.busy = r_d.st == ST_CAL;
        // ------------------------------------------------------------
        // lane drive
        // ------------------------------------------------------------
        // calibration bits alternate each byte clock
        r_d.laneD = '0;
        r_d.laneH = '0;
        if (enable && forceLp == ctp_pkg::LP_NORMAL) begin
            if (r_q.st == ST_CAL) begin
                r_d.laneD = {ctp_pkg::NUM_LANES{pattern[~beatIdx[2:0]]}} & laneMask;
                r_d.laneH = laneMask;
            end else if (r_q.st == ST_DATA) begin
                r_d.laneD = r_q.dataByte[ctp_pkg::NUM_LANES-1:0] & laneMask;
                r_d.laneH = laneMask;
            end
        end
        // LP00 on data lanes (01) or also clock lane (11)
        // clock lane kept running after first packet in free mode
        r_d.clkRun = enable && forceLp != ctp_pkg::LP_ALL
                   && ((r_q.portCtl[ctp_pkg::BIT_FREE_CLK] && r_q.firstPkt)
                       || r_q.st == ST_DATA || r_q.st == ST_CAL);
        r_d.clkHs = r_d.clkRun && bclk;
        if (!enable) begin
            r_d.firstPkt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q <= '0;
            r_q.calCtl <= ctp_pkg::RST_CAL_CTL;
            r_q.portCtl <= ctp_pkg::RST_PORT_CTL;
            r_q.st <= ST_INIT;
        end else begin
            r_q <= r_d;
        end
    end

    assign wb_dat_o   = r_q.rdat;
    assign wb_ack_o   = r_q.ack;
    assign laneData   = r_q.laneD;
    assign laneHs     = r_q.laneH;
    assign clkLaneRun = r_q.clkRun;
    assign clkLaneHs  = r_q.clkHs;
    assign txActive   = r_q.active;
    assign calBusy    = r_q.busy;
    assign txPass     = r_q.pass;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_lanes_off_disabled: assert property (!enable |=> laneHs == '0)
        else $error("lanes driven while disabled");
    a_lp_data_forced: assert property (forceLp != 2'b00 |=> laneHs == '0)
        else $error("data lanes not in LP00");
    a_lp_clock_forced: assert property (forceLp == 2'b11 |=> !clkLaneRun)
        else $error("clock lane not in LP00");
    a_lane_count_mask: assert property ((laneHs & ~laneMask) == '0 || $changed(laneSel))
        else $error("lane outside count active");
    a_single_clears: assert property (r_q.st == ST_CAL && byteTick && enable
        && r_q.calCnt == 8'h01 && !(wbReq && wb_we_i) |=> !r_q.calCtl[1])
        else $error("one-shot did not clear");
    a_no_data_during_init: assert property (r_q.st == ST_INIT && enable && byteTick
        && r_q.portCtl[ctp_pkg::BIT_INIT_CAL] |=> calBusy)
        else $error("data before init");
    a_pass_error_clear: assert property (errS |=> !txPass)
        else $error("pass kept during error");
    a_pass_all_mode: assert property (r_q.calCtl[3] && !allOk |=> !txPass)
        else $error("pass without all ports");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    c_cal_done: cover property (r_q.st == ST_CAL ##1 r_q.st == ST_IDLE);
    c_data_sent: cover property (fPop);
    c_pass_up: cover property ($rose(txPass));
endmodule
`default_nettype wire

// ---- bench/ctp_rx_model.sv ----
// receiver model on the far side: counts high speed beats on the lanes
`timescale 1ns/1ps
`default_nettype none
module ctp_rx_model (
    input  wire logic       byteClk,
    input  wire logic       clr,
    input  wire logic [3:0] laneData,
    input  wire logic [3:0] laneHs,
    output logic      [7:0] nBeats,
    output logic            firstBit,
    output logic            altOk,
    output logic      [3:0] hsSeen
);
    logic lastBit;
    // ------------------------------------------------------------
    // beat capture
    // ------------------------------------------------------------
    // sampled mid-beat, the lanes settle a few cycles after the edge
    // alternation from first beat
    always @(negedge byteClk or posedge clr) begin
        if (clr) begin
            nBeats <= 8'h00;
            altOk  <= 1'b1;
            hsSeen <= 4'h0;
        end else if (laneHs[0]) begin
            if (nBeats == 8'h00) begin
                firstBit <= laneData[0];
            end else if (laneData[0] === lastBit) begin
                altOk <= 1'b0;
            end
            lastBit <= laneData[0];
            nBeats  <= nBeats + 8'h01;
            hsSeen  <= hsSeen | laneHs;
        end
    end
endmodule
`default_nettype wire

// ---- bench/ctp_port_ctrl_tb_top.sv ----
// testbench for the transmit port control block
`timescale 1ns/1ps
`default_nettype none
module ctp_port_ctrl_tb_top;
    localparam logic [9:0]  AP = ctp_pkg::ADDR_PORT_CTL;
    localparam logic [9:0]  AC = ctp_pkg::ADDR_CAL_CTL;
    localparam logic [9:0]  AS = ctp_pkg::ADDR_PASS_STS;
    localparam logic [9:0]  AF = ctp_pkg::ADDR_FWD_CTL;
    localparam logic [7:0]  CL = ctp_pkg::CAL_LEN;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [3:0]  sel = 4'hF;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        ack;
    logic [7:0]  pixData = 8'h00;
    logic        pixValid = 1'b0;
    logic        pixReady;
    logic        frameEnd = 1'b0;
    logic [1:0]  rxEn = 2'b00;
    logic [1:0]  rxVid = 2'b00;
    logic        txError = 1'b0;
    logic        byteClk = 1'b0;
    logic [3:0]  laneData;
    logic [3:0]  laneHs;
    logic        clkRun;
    logic        clkHs;
    logic        calBusy;
    logic        txActive;
    logic        txPass;
    logic        clr = 1'b0;
    logic [7:0]  nBeats;
    logic        firstBit;
    logic        altOk;
    logic [3:0]  hsSeen;
    logic [31:0] q;
    logic [3:0]  masks [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
    int          acc;
    int          mismatches = 0;
    int          n_tests = 0;

    always #5 clk = ~clk;
    // link clock at one eighth of clk, edges 3 ns after a falling clk edge
    initial begin
        #3;
        forever #40 byteClk = ~byteClk;
    end

    ctp_port_ctrl i_ctp_port_ctrl (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .pixData(pixData), .pixValid(pixValid), .pixReady(pixReady),
        .frameEnd(frameEnd), .rxEnabled(rxEn), .rxVideoValid(rxVid), .txError(txError),
        .byteClk(byteClk), .laneData(laneData), .laneHs(laneHs), .clkLaneRun(clkRun),
        .clkLaneHs(clkHs), .txActive(txActive), .calBusy(calBusy), .txPass(txPass));
    ctp_rx_model i_ctp_rx_model (.byteClk(byteClk), .clr(clr), .laneData(laneData),
        .laneHs(laneHs), .nBeats(nBeats), .firstBit(firstBit), .altOk(altOk), .hsSeen(hsSeen));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // classic cycle, held until ack is sampled high
    task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {22'h0, a};
        wdat <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            complete_run();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdChk(input string nm, input logic [9:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(nm, q, exp);
    endtask
    task automatic clrModel;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
    endtask
    // valid held until ready is seen at an edge
    task automatic push(input int n);
        acc = 0;
        pixData <= 8'h00;
        pixValid <= 1'b1;
        for (int k = 0; k < 200 && acc < n; k++) begin
            @(posedge clk);
            if (pixReady === 1'b1) begin
                acc++;
                pixData <= pixData + 8'h01;
            end
        end
        pixValid <= 1'b0;
    endtask
    task automatic waitFor(input string nm, ref logic s, input logic v, input int n);
        for (int k = 0; k < n && s !== v; k++) @(posedge clk);
        chk(nm, 32'(s), 32'(v));
    endtask
    // settle margin lets a stray extra sequence show up in the count
    task automatic waitBeats(input logic [7:0] n);
        for (int k = 0; k < 1000 && nBeats < n; k++) @(posedge clk);
        repeat (80) @(posedge clk);
        chk("beats", 32'(nBeats), 32'(n));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdChk("portRst", AP, 32'h00);
        rdChk("calRst", AC, 32'h40);
        rdChk("unmapped", 10'h100, 32'h0);
        wr(AP, 8'hFE);
        rdChk("portMask", AP, 32'h7E);
        wr(AP, 8'h00);
        wr(AF, 8'h01);
        wr(AP, 8'h20);
        rdChk("dupLanes", AP, 32'h20);
        rdChk("dupRd", AF, 32'h1);
        wr(AF, 8'h00);
        $display("test registers done");
        clrModel();
        push(17);
        chk("fillCount", 32'(acc), 32'(ctp_pkg::FIFO_DEPTH));
        chk("fullRefuse", 32'(pixReady), 32'h0);
        chk("noDrive", 32'(hsSeen), 32'h0);
        wr(AP, 8'h01);
        waitFor("active", txActive, 1'b1, 50);
        waitBeats(8'h10);
        chk("dataFirst", 32'(firstBit), 32'h0);
        chk("dataOrder", 32'(altOk), 32'h1);
        waitFor("drained", pixReady, 1'b1, 20);
        $display("test enable done");
        for (int lc = 0; lc < 4; lc++) begin
            wr(AP, 8'h00);
            clrModel();
            wr(AP, 8'({lc[1:0], 4'h1}));
            push(16);
            waitBeats(8'h10);
            chk("laneMask", 32'(hsSeen), 32'(masks[lc]));
        end
        $display("test lanes done");
        wr(AP, 8'h00);
        clrModel();
        wr(AP, 8'h05);
        push(4);
        repeat (200) @(posedge clk);
        chk("forceData", 32'(hsSeen), 32'h0);
        // free clock on too, so only the force keeps the clock lane quiet
        wr(AP, 8'h0F);
        repeat (20) @(posedge clk);
        chk("forceClk", 32'(clkHs), 32'h0);
        chk("forceRun", 32'(clkRun), 32'h0);
        wr(AP, 8'h01);
        repeat (200) @(posedge clk);
        $display("test force done");
        wr(AP, 8'h00);
        clrModel();
        // initial calibration enabled as for the fastest lane rate
        wr(AP, 8'h41);
        waitFor("initCal", calBusy, 1'b1, 50);
        waitBeats(CL);
        chk("patFirst", 32'(firstBit), 32'h0);
        chk("patAlt", 32'(altOk), 32'h1);
        wr(AP, 8'h00);
        clrModel();
        wr(AC, 8'h06);
        wr(AC, 8'h06);
        wr(AP, 8'h01);
        waitBeats(CL);
        chk("invFirst", 32'(firstBit), 32'h1);
        rdChk("singleClr", AC, 32'h44);
        clrModel();
        wr(AC, 8'h01);
        frameEnd <= 1'b1;
        repeat (3) @(posedge clk);
        frameEnd <= 1'b0;
        waitBeats(CL);
        chk("perAlt", 32'(altOk), 32'h1);
        wr(AC, 8'h00);
        $display("test calibration done");
        clrModel();
        wr(AP, 8'h03);
        push(4);
        waitBeats(8'h04);
        repeat (50) @(posedge clk);
        chk("freeClk", 32'(clkRun), 32'h1);
        $display("test clock done");
        rxEn <= 2'b11;
        rxVid <= 2'b01;
        push(4);
        waitFor("passAny", txPass, 1'b1, 300);
        rdChk("passSts", AS, 32'h1);
        wr(AC, 8'h08);
        waitFor("passAllNo", txPass, 1'b0, 20);
        rxVid <= 2'b11;
        push(4);
        waitFor("passAll", txPass, 1'b1, 300);
        txError <= 1'b1;
        waitFor("passErr", txPass, 1'b0, 20);
        txError <= 1'b0;
        $display("test pass done");
        complete_run();
    end
endmodule
`default_nettype wire
